// ==== src/acs_map.svh ====
/*
 * Register offsets, field positions, reset values and conversion counts
 * of the converter sequencing block.
 * Assumes a 32-bit word-addressed register port; byte addresses are used.
 */
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ACS_ADDR_CTRL   32'hFFFF0500
`define ACS_ADDR_POS    32'hFFFF0504
`define ACS_ADDR_NEG    32'hFFFF0508
`define ACS_ADDR_STAT   32'hFFFF050C
`define ACS_ADDR_DATA   32'hFFFF0510
`define ACS_ADDR_RST    32'hFFFF0514
`define ACS_ADDR_GAIN   32'hFFFF0518
`define ACS_ADDR_PCFG   32'hFFFF051C

// ----------------------------------------------------------------------
// control field positions and codes
// ----------------------------------------------------------------------
`define ACS_CTRL_RST    16'h0A00
`define ACS_DIV_HI      13
`define ACS_DIV_LO      11
`define ACS_ACQ_HI      10
`define ACS_ACQ_LO      8
`define ACS_EN_BIT      7
`define ACS_PWR_BIT     5
`define ACS_MODE_HI     4
`define ACS_MODE_LO     3
`define ACS_TRIG_HI     2
`define ACS_TRIG_LO     0
`define ACS_MODE_DIFF   2'h1
`define ACS_TRIG_PIN    3'h0
`define ACS_TRIG_TMR1   3'h1
`define ACS_TRIG_TMR0   3'h2
`define ACS_TRIG_SW1    3'h3
`define ACS_TRIG_SWC    3'h4
`define ACS_TRIG_PLA    3'h5

// ----------------------------------------------------------------------
// channel codes, other reset values and counts
// ----------------------------------------------------------------------
`define ACS_CH_TEMP     5'h0D
`define ACS_SEL_RST     5'h00
`define ACS_GAIN_RST    5'h00
`define ACS_TRIAL_CLKS  5'h13
`define ACS_TEMP_ACQ    7'h10
`define ACS_TEMP_DIVM1  5'h1F
`define ACS_RESULT_LO   16

`endif

// ==== src/acs_pkg.sv ====
/*
 * Types of the converter sequencing block.
 * Assumes acs_map.svh for all numeric constants.
 */
package acs_pkg;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_ACQ   = 3'h2,
      ST_TRIAL = 3'h4
   } acs_state_t;

   // settings handed to the analog front end
   typedef struct packed {
      logic [4:0] pos_sel;
      logic [4:0] neg_sel;
      logic [4:0] gain;
      logic [1:0] mode;
      logic [1:0] bypass;
      logic       power;
      logic       sample;
   } acs_front_t;

endpackage : acs_pkg

// ==== src/acs_top.sv ====
/*
 * Sequencing and register logic around a 12-bit successive-approximation
 * converter: clock divider, acquisition and trial counts, temperature
 * channel override, ready flag, busy output and register reset.
 * Assumes the bit-trial engine returns its result on trial_result_in in
 * the core clock domain, valid on the last trial clock.
 */
// Decided for this implementation: the strobed register port.
// What this block does
// - after reset acquisition is eight converter clocks, divide ratio two
// - every conversion spends 19 converter clocks on trials and writing
// - temperature channel forces acquisition 16 clocks and divide 32
// - user divider and acquisition settings return for other channels
// - temperature sensor is one more positive channel of the mux
// - status register holds only the ready flag, at bit 0
// - conversion end sets ready flag and raises the interrupt request
// - reading the result register clears the ready flag
// - busy output stays high through the whole conversion
// - busy output falls as soon as the conversion finishes
// - busy appears on port pin two only when port config selects it
// - writing the reset register returns all registers to defaults
// - result register holds the latest 12-bit conversion result
// - control selects enable, input mode and trigger source
// - control sits at FFFF0500 and resets to 00000A00
// - a dedicated register selects the positive input channel
// - a dedicated register selects the negative input channel
// - a gain register sets amplifier gain of the two gain inputs
// - control bits 13:11 divide core clock by 1 to 32
// - control bits 10:8 select 2 to 64 acquisition clocks
// - single software trigger code rewrites itself to 000 when done
// - conversions start only while control bit 7 is set
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_top (
   input wire logic clk_sys_in, // core clock, 40 MHz
   input wire logic rst_in, // async reset, active high
   input wire logic [31:0] addr_in, // register byte address
   input wire logic [31:0] wdata_in, // register write data
   input wire logic wr_in, // write strobe
   input wire logic rd_in, // read strobe
   output logic [31:0] rdata_out, // read data, cycle after rd_in
   input wire logic convst_pin_in, // external start pin, async
   input wire logic timer0_in, // timer 0 overflow pulse
   input wire logic timer1_in, // timer 1 overflow pulse
   input wire logic pla_in, // logic array start pulse
   input wire logic [11:0] trial_result_in, // bit-trial engine result
   output acs_pkg::acs_front_t front_out, // analog front-end settings
   output logic adc_clk_en_out, // converter clock enable pulse
   output logic busy_out, // conversion busy
   output logic irq_out, // converter interrupt request
   output logic port_zero_pin_two_out, // port pin two drive
   output logic port_zero_pin_two_oe_out // port pin two output enable
);

   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------
   // divider code to ratio minus one; reserved codes act as divide by 32
   function automatic logic [4:0] div_m1(input logic [2:0] code);
      case (code)
         3'h0: div_m1 = 5'h00;
         3'h1: div_m1 = 5'h01;
         3'h2: div_m1 = 5'h03;
         3'h3: div_m1 = 5'h07;
         3'h4: div_m1 = 5'h0F;
         default: div_m1 = 5'h1F;
      endcase
   endfunction : div_m1

   // acquisition code to clock count; reserved codes act as 64
   function automatic logic [6:0] acq_len(input logic [2:0] code);
      case (code)
         3'h0: acq_len = 7'h02;
         3'h1: acq_len = 7'h04;
         3'h2: acq_len = 7'h08;
         3'h3: acq_len = 7'h10;
         3'h4: acq_len = 7'h20;
         default: acq_len = 7'h40;
      endcase
   endfunction : acq_len

   function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
      hit = (a == b);
   endfunction : hit

   // ----------------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------------
   logic [15:0] ctrl_r;
   logic [4:0] pos_r;
   logic [4:0] neg_r;
   logic [4:0] gain_r;
   logic pcfg_r;
   logic ready_r;
   logic [11:0] result_r;
   logic [31:0] rdata_r;
   acs_pkg::acs_state_t st_r;
   acs_pkg::acs_state_t st_nxt;
   logic [4:0] div_cnt_r;
   logic [4:0] div_m1_r;
   logic [6:0] acq_r;
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic conv_s1_r;
   logic conv_s2_r;

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   wire wr_ctrl = wr_in & hit(addr_in, `ACS_ADDR_CTRL);
   wire wr_pos = wr_in & hit(addr_in, `ACS_ADDR_POS);
   wire wr_neg = wr_in & hit(addr_in, `ACS_ADDR_NEG);
   wire wr_gain = wr_in & hit(addr_in, `ACS_ADDR_GAIN);
   wire wr_pcfg = wr_in & hit(addr_in, `ACS_ADDR_PCFG);
   wire soft_rst = wr_in & hit(addr_in, `ACS_ADDR_RST);
   wire rd_data = rd_in & hit(addr_in, `ACS_ADDR_DATA);

   // ----------------------------------------------------------------------
   // control fields and effective timing
   // ----------------------------------------------------------------------
   wire [2:0] trig = ctrl_r[`ACS_TRIG_HI:`ACS_TRIG_LO];
   wire conv_en = ctrl_r[`ACS_EN_BIT];
   wire is_temp = (pos_r == `ACS_CH_TEMP);
   // override while the temperature channel is picked, user values else
   wire [4:0] eff_div = is_temp ? `ACS_TEMP_DIVM1
      : div_m1(ctrl_r[`ACS_DIV_HI:`ACS_DIV_LO]);
   wire [6:0] eff_acq = is_temp ? `ACS_TEMP_ACQ
      : acq_len(ctrl_r[`ACS_ACQ_HI:`ACS_ACQ_LO]);

   // ----------------------------------------------------------------------
   // start pin synchroniser
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         conv_s1_r <= 1'b0;
         conv_s2_r <= 1'b0;
      end else begin
         conv_s1_r <= convst_pin_in;
         conv_s2_r <= conv_s1_r;
      end
   end

   // ----------------------------------------------------------------------
   // trigger selection
   // ----------------------------------------------------------------------
   // pulses that land while busy are dropped; a held pin level restarts
   logic trig_hit;
   always_comb begin
      case (trig)
         `ACS_TRIG_PIN: trig_hit = conv_s2_r;
         `ACS_TRIG_TMR1: trig_hit = timer1_in;
         `ACS_TRIG_TMR0: trig_hit = timer0_in;
         `ACS_TRIG_SW1: trig_hit = 1'b1;
         `ACS_TRIG_SWC: trig_hit = 1'b1;
         `ACS_TRIG_PLA: trig_hit = pla_in;
         default: trig_hit = 1'b0;
      endcase
   end
   wire start = conv_en & trig_hit & (st_r == acs_pkg::ST_IDLE);

   // ----------------------------------------------------------------------
   // converter clock divider
   // ----------------------------------------------------------------------
   // restarted on each start so the first converter clock has full length
   wire ce = (st_r != acs_pkg::ST_IDLE) && (div_cnt_r == div_m1_r);
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         div_cnt_r <= 5'h00;
      end else if (start || ce || soft_rst) begin
         div_cnt_r <= 5'h00;
      end else if (st_r != acs_pkg::ST_IDLE) begin
         div_cnt_r <= div_cnt_r + 5'h01;
      end
   end

   // ----------------------------------------------------------------------
   // sequencer next state
   // ----------------------------------------------------------------------
   wire acq_end = ce && (cnt_r == acq_r - 7'h01);
   wire done = (st_r == acs_pkg::ST_TRIAL) && ce
      && (cnt_r == {2'h0, `ACS_TRIAL_CLKS} - 7'h01);
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         acs_pkg::ST_IDLE: begin
            cnt_nxt = 7'h00;
            if (start) begin
               st_nxt = acs_pkg::ST_ACQ;
            end
         end
         acs_pkg::ST_ACQ: begin
            if (acq_end) begin
               st_nxt = acs_pkg::ST_TRIAL;
               cnt_nxt = 7'h00;
            end else if (ce) begin
               cnt_nxt = cnt_r + 7'h01;
            end
         end
         acs_pkg::ST_TRIAL: begin
            if (done) begin
               st_nxt = acs_pkg::ST_IDLE;
               cnt_nxt = 7'h00;
            end else if (ce) begin
               cnt_nxt = cnt_r + 7'h01;
            end
         end
         default: begin
            st_nxt = acs_pkg::ST_IDLE;
            cnt_nxt = 7'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // sequencer registers; timing is frozen at start for the whole sample
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= acs_pkg::ST_IDLE;
         cnt_r <= 7'h00;
         div_m1_r <= 5'h00;
         acq_r <= 7'h02;
      end else if (soft_rst) begin
         st_r <= acs_pkg::ST_IDLE;
         cnt_r <= 7'h00;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         if (start) begin
            div_m1_r <= eff_div;
            acq_r <= eff_acq;
         end
      end
   end

   // ----------------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------------
   // a software write to control wins over the single-shot rewrite
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_r <= `ACS_CTRL_RST;
         pos_r <= `ACS_SEL_RST;
         neg_r <= `ACS_SEL_RST;
         gain_r <= `ACS_GAIN_RST;
         pcfg_r <= 1'b0;
      end else if (soft_rst) begin
         ctrl_r <= `ACS_CTRL_RST;
         pos_r <= `ACS_SEL_RST;
         neg_r <= `ACS_SEL_RST;
         gain_r <= `ACS_GAIN_RST;
         pcfg_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= wdata_in[15:0];
         end else if (done && trig == `ACS_TRIG_SW1) begin
            ctrl_r[`ACS_TRIG_HI:`ACS_TRIG_LO] <= `ACS_TRIG_PIN;
         end
         if (wr_pos) begin
            pos_r <= wdata_in[4:0];
         end
         if (wr_neg) begin
            neg_r <= wdata_in[4:0];
         end
         if (wr_gain) begin
            gain_r <= wdata_in[4:0];
         end
         if (wr_pcfg) begin
            pcfg_r <= wdata_in[0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // result and ready flag; a set in the clearing cycle wins
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ready_r <= 1'b0;
         result_r <= 12'h000;
      end else if (soft_rst) begin
         ready_r <= 1'b0;
         result_r <= 12'h000;
      end else if (done) begin
         ready_r <= 1'b1;
         result_r <= trial_result_in;
      end else if (rd_data) begin
         ready_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // read data, valid only in the cycle after the strobe
   // ----------------------------------------------------------------------
   // twos complement results are sign-extended into the top bits
   wire sx = result_r[11] && (ctrl_r[`ACS_MODE_HI:`ACS_MODE_LO]
      == `ACS_MODE_DIFF);
   wire [31:0] data_word = {{4{sx}}, result_r, 16'h0000};
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(addr_in, `ACS_ADDR_CTRL)) rd_mux = {16'h0000, ctrl_r};
      if (hit(addr_in, `ACS_ADDR_POS)) rd_mux = {27'h0, pos_r};
      if (hit(addr_in, `ACS_ADDR_NEG)) rd_mux = {27'h0, neg_r};
      if (hit(addr_in, `ACS_ADDR_STAT)) rd_mux = {31'h0, ready_r};
      if (hit(addr_in, `ACS_ADDR_DATA)) rd_mux = data_word;
      if (hit(addr_in, `ACS_ADDR_GAIN)) rd_mux = {27'h0, gain_r};
      if (hit(addr_in, `ACS_ADDR_PCFG)) rd_mux = {31'h0, pcfg_r};
   end
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rd_in ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   wire busy = (st_r != acs_pkg::ST_IDLE);
   assign rdata_out = rdata_r;
   assign busy_out = busy;
   assign irq_out = ready_r;
   assign adc_clk_en_out = ce;
   assign port_zero_pin_two_out = pcfg_r & busy;
   assign port_zero_pin_two_oe_out = pcfg_r;
   assign front_out.pos_sel = pos_r;
   assign front_out.neg_sel = neg_r;
   assign front_out.gain = gain_r;
   assign front_out.mode = ctrl_r[`ACS_MODE_HI:`ACS_MODE_LO];
   assign front_out.bypass = ctrl_r[15:14];
   assign front_out.power = ctrl_r[`ACS_PWR_BIT];
   assign front_out.sample = (st_r == acs_pkg::ST_ACQ);

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   sequence s_start_user;
      start && !soft_rst && !is_temp;
   endsequence
   sequence s_start_temp;
      start && !soft_rst && is_temp;
   endsequence

   soft_reset_a: assert property (soft_rst |=> ctrl_r == 16'h0A00
      && pos_r == 5'h00 && !ready_r && !busy)
      else $error("register reset left a register changed");
   temp_force_a: assert property (s_start_temp |=> div_m1_r == 5'h1F
      && acq_r == 7'h10)
      else $error("temperature override not applied");
   user_restore_a: assert property (s_start_user |=> acq_r ==
      acq_len($past(ctrl_r[10:8])) && div_m1_r == div_m1($past(ctrl_r[13:11])))
      else $error("user timing not restored");
   trial_len_a: assert property (done |-> st_r == acs_pkg::ST_TRIAL
      && cnt_r == 7'h12)
      else $error("trial phase length wrong");
   acq_len_a: assert property ((st_r == acs_pkg::ST_ACQ) |-> cnt_r < acq_r)
      else $error("acquisition count overran");
   ready_set_a: assert property (done |=> ready_r && !busy)
      else $error("ready flag not set at conversion end");
   // ready may already stand from an unread result; a reset abort is exempt
   busy_ready_a: assert property ($fell(busy) && !$past(soft_rst) |->
      ready_r && $past(done))
      else $error("ready did not rise with busy falling");
   read_clear_a: assert property (rd_data && !done && !soft_rst |=>
      !ready_r)
      else $error("result read did not clear ready flag");
   single_shot_a: assert property (done && trig == 3'h3 && !wr_ctrl
      |=> trig == 3'h0)
      else $error("single trigger code not rewritten");
   enable_gate_a: assert property (!conv_en && !busy |=> !busy)
      else $error("conversion started while disabled");
   pin_route_a: assert property (!pcfg_r |-> !port_zero_pin_two_oe_out
      && !port_zero_pin_two_out)
      else $error("busy driven on pin without selection");

endmodule : acs_top

// ==== test/acs_front_model.sv ====
/*
 * Behavioural model of the analog front end and bit-trial engine.
 * Assumes the block's busy level and sample flag, core clock domain.
 */
`timescale 1ns/1ps

module acs_front_model (
   input wire logic clk_sys_in, // core clock
   input wire logic rst_in, // async reset, active high
   input wire acs_pkg::acs_front_t front_in, // settings from the block
   input wire logic busy_in, // conversion busy
   input wire logic [11:0] level_in, // analog level as a code
   output logic [11:0] result_out // bit-trial result
);
   // the code is held only during the trial phase; elsewhere the lines
   // toggle every cycle, so a result taken at the wrong moment is wrong
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         result_out <= 12'hA5A;
      end else if (busy_in && !front_in.sample) begin
         result_out <= level_in;
      end else begin
         result_out <= ~result_out;
      end
   end
endmodule : acs_front_model

// ==== test/acs_top_tb.sv ====
/*
 * Self-checking testbench of the converter sequencing block.
 * Assumes acs_map.svh for addresses and the front-end model beside it.
 */
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_top_tb;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic convst_pin_in = 1'b0;
   logic timer0_in = 1'b0;
   logic timer1_in = 1'b0;
   logic pla_in = 1'b0;
   logic pcfg_v = 1'b0;
   logic [31:0] addr_in = 32'h0;
   logic [31:0] wdata_in = 32'h0;
   logic [31:0] rdata_out;
   logic [11:0] level = 12'h0;
   logic [11:0] trial_result_in;
   acs_pkg::acs_front_t front_out;
   logic adc_clk_en_out;
   logic busy_out;
   logic irq_out;
   logic pin_out;
   logic pin_oe;
   logic [2:0] tc [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
   int num_errors = 0;
   int checks_done = 0;
   int ce_seen = 0;
   int seed = 32'ha096;

   acs_top dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .convst_pin_in(convst_pin_in),
      .timer0_in(timer0_in), .timer1_in(timer1_in), .pla_in(pla_in),
      .trial_result_in(trial_result_in), .front_out(front_out),
      .adc_clk_en_out(adc_clk_en_out), .busy_out(busy_out),
      .irq_out(irq_out), .port_zero_pin_two_out(pin_out),
      .port_zero_pin_two_oe_out(pin_oe));

   acs_front_model model (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .front_in(front_out), .busy_in(busy_out), .level_in(level),
      .result_out(trial_result_in));

   initial begin
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end

   // ---------------------------------------------------------------
   // checking and bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, d);
      @(posedge clk_sys_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rchk(input string nm, input logic [31:0] a, e);
      @(posedge clk_sys_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 chk(nm, e, rdata_out);
   endtask : rchk

   function automatic logic [31:0] exp_data(logic [11:0] lv, logic [1:0] md);
      exp_data = {(md == `ACS_MODE_DIFF) ? {4{lv[11]}} : 4'h0, lv, 16'h0};
   endfunction : exp_data

   // acquisition clocks plus 19 trial clocks, times the divide ratio
   function automatic int conv_len(int dv, int aq);
      conv_len = ((32'h2 << aq) + 32'h13) * (32'h1 << dv);
   endfunction : conv_len

   // bounded wait for busy, then count its high cycles
   task automatic meas(input int len);
      int i;
      int n;
      i = 0;
      n = 0;
      #1;
      while (busy_out !== 1'b1 && i < 10) begin
         @(posedge clk_sys_in);
         #1 i++;
      end
      chk("pin_busy", pcfg_v, pin_out);
      chk("pin_oe", pcfg_v, pin_oe);
      ce_seen = 0;
      while (busy_out === 1'b1 && n < 3000) begin
         n++;
         if (adc_clk_en_out === 1'b1) ce_seen++;
         @(posedge clk_sys_in);
         #1;
      end
      chk("busy_len", len, n);
      chk("ready_at_fall", 1, irq_out);
      chk("pin_idle", 0, pin_out);
   endtask : meas

   task automatic conv(input int len, input logic [11:0] lv,
         input logic [1:0] md);
      meas(len);
      rchk("status_set", `ACS_ADDR_STAT, 32'h1);
      rchk("result", `ACS_ADDR_DATA, exp_data(lv, md));
      rchk("status_clear", `ACS_ADDR_STAT, 32'h0);
      chk("irq_clear", 0, irq_out);
   endtask : conv

   task automatic quiet(input int cyc);
      int h;
      h = 0;
      repeat (cyc) begin
         @(posedge clk_sys_in);
         #1 if (busy_out === 1'b1) h++;
      end
      chk("no_start", 0, h);
   endtask : quiet

   // every register back at its default; 0520 is unmapped
   task automatic regs_default();
      rchk("ctrl_dflt", `ACS_ADDR_CTRL, 32'h00000A00);
      for (int a = 1; a < 9; a++) begin
         rchk("reg_dflt", `ACS_ADDR_CTRL + 4 * a, 32'h0);
      end
   endtask : regs_default

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      int dv;
      int aq;
      logic [1:0] md;
      logic [11:0] lv;
      logic [31:0] ctl;
      repeat (6) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      regs_default();
      chk("front_rst", 0, front_out);
      $display("test reset done");
      // default timing, single software conversion rewrites its code
      level <= 12'h5C3;
      wr(`ACS_ADDR_CTRL, 32'h00000A83);
      conv(54, 12'h5C3, 2'h0);
      chk("clk_en_count", 27, ce_seen);
      rchk("ctrl_sw", `ACS_ADDR_CTRL, 32'h00000A80);
      $display("test single done");
      // extremes first, then random divide and acquisition codes
      for (int k = 0; k < 6; k++) begin
         dv = (k == 0) ? 5 : (k == 1) ? 0 : $unsigned($random(seed)) % 6;
         aq = (k == 0) ? 5 : (k == 1) ? 0 : $unsigned($random(seed)) % 6;
         md = 2'(k % 3);
         lv = 12'($random(seed));
         ctl = 32'h83 | (dv << 11) | (aq << 8) | (32'(md) << 3);
         level <= lv;
         wr(`ACS_ADDR_CTRL, ctl);
         conv(conv_len(dv, aq), lv, md);
         chk("clk_en_count", (2 << aq) + 19, ce_seen);
         chk("mode_out", md, front_out.mode);
         rchk("ctrl_back", `ACS_ADDR_CTRL, ctl & ~32'h7);
      end
      $display("test timing done");
      // every external trigger source; nothing starts before its pulse
      for (int k = 0; k < 4; k++) begin
         wr(`ACS_ADDR_CTRL, 32'h00000A80 | tc[k]);
         quiet(4);
         level <= 12'($random(seed));
         @(posedge clk_sys_in);
         convst_pin_in <= (tc[k] == 3'h0);
         timer1_in <= (tc[k] == 3'h1);
         timer0_in <= (tc[k] == 3'h2);
         pla_in <= (tc[k] == 3'h5);
         @(posedge clk_sys_in);
         {convst_pin_in, timer1_in, timer0_in, pla_in} <= 4'h0;
         conv(54, level, 2'h0);
      end
      $display("test triggers done");
      // continuous mode restarts; clearing enable stops further starts
      wr(`ACS_ADDR_CTRL, 32'h00000A84);
      meas(54);
      meas(54);
      wr(`ACS_ADDR_CTRL, 32'h00000A04);
      repeat (60) @(posedge clk_sys_in);
      quiet(200);
      wr(`ACS_ADDR_CTRL, 32'h00000A03);
      quiet(100);
      rchk("data_flush", `ACS_ADDR_DATA, exp_data(level, 2'h0));
      $display("test enable done");
      // temperature channel forces 16 clocks at 32, user timing returns
      wr(`ACS_ADDR_POS, 32'h0D);
      #1 chk("pos_out", 5'h0D, front_out.pos_sel);
      wr(`ACS_ADDR_CTRL, 32'h00000083);
      conv(1120, level, 2'h0);
      chk("clk_en_count", 35, ce_seen);
      wr(`ACS_ADDR_POS, 32'h02);
      wr(`ACS_ADDR_CTRL, 32'h00000083);
      conv(21, level, 2'h0);
      chk("clk_en_count", 21, ce_seen);
      $display("test temperature done");
      // channel, gain and port registers, then the register reset
      wr(`ACS_ADDR_NEG, 32'h0C);
      wr(`ACS_ADDR_GAIN, 32'h15);
      wr(`ACS_ADDR_PCFG, 32'h1);
      pcfg_v = 1'b1;
      rchk("neg_back", `ACS_ADDR_NEG, 32'h0C);
      rchk("gain_back", `ACS_ADDR_GAIN, 32'h15);
      chk("neg_out", 5'h0C, front_out.neg_sel);
      chk("gain_out", 5'h15, front_out.gain);
      wr(`ACS_ADDR_CTRL, 32'h00000AA3);
      conv(54, level, 2'h0);
      chk("power_out", 1, front_out.power);
      wr(`ACS_ADDR_CTRL, 32'h00000A83);
      repeat (10) @(posedge clk_sys_in);
      wr(`ACS_ADDR_RST, 32'h1);
      @(posedge clk_sys_in);
      #1 chk("busy_abort", 0, busy_out);
      pcfg_v = 1'b0;
      chk("oe_rst", 0, pin_oe);
      regs_default();
      $display("test soft reset done");
      wrap_up();
   end

   // cut a hang well beyond the longest expected run
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      num_errors++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule : acs_top_tb
